// File: core/hjd_map.svh
// Register indices, field positions, reset values and timing counts
// Assumes inclusion by the headset jack detect top module only
`ifndef HJD_MAP_SVH
`define HJD_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define HJD_IDX_TIMING_CFG 8'h19
`define HJD_IDX_SENSE_CFG 8'h1A
`define HJD_IDX_DEBOUNCE_CFG 8'h1B
`define HJD_IDX_STATUS 8'h1C
`define HJD_IDX_IRQ_STATUS 8'h20
`define HJD_IDX_IRQ_MASK 8'h21

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define HJD_RST_TIMING_CFG 8'h00
`define HJD_RST_SENSE_CFG 8'h00
`define HJD_RST_DEBOUNCE_CFG 8'h00
`define HJD_RST_IRQ 4'h0
`define HJD_WMASK_TIMING_CFG 8'hFF
`define HJD_WMASK_SENSE_CFG 8'hFE
`define HJD_WMASK_DEBOUNCE_CFG 8'h7F

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HJD_TIM_RATE_HI 7
`define HJD_TIM_RATE_LO 6
`define HJD_TIM_HP_PER_HI 2
`define HJD_TIM_HP_PER_LO 1
`define HJD_SNS_THRESH_HI 5
`define HJD_SNS_THRESH_LO 4
`define HJD_SNS_COUPLING 3
`define HJD_SNS_DOUBLE_CUR 2
`define HJD_SNS_ENABLE 1
`define HJD_DEB_HP 6
`define HJD_DEB_INS_HI 5
`define HJD_DEB_INS_LO 3
`define HJD_DEB_REMOVAL 2
`define HJD_DEB_HOOK_HI 1
`define HJD_DEB_HOOK_LO 0
`define HJD_NUM_EVENTS 4
`define HJD_EV_JACK 0
`define HJD_EV_HEADSET 1
`define HJD_EV_HOOK_PRESS 2
`define HJD_EV_HOOK_RELEASE 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HJD_CLK_HZ 20000000
`define HJD_TICK_MS 1
`define HJD_MS_CYCLES ((`HJD_CLK_HZ / 1000) * `HJD_TICK_MS)
`define HJD_RATE_DHZ_0 5
`define HJD_RATE_DHZ_1 10
`define HJD_RATE_DHZ_2 75
`define HJD_RATE_DHZ_3 150
`define HJD_DHZ_TO_MS 10000
`define HJD_HP_PER_MS_0 1
`define HJD_HP_PER_MS_1 2
`define HJD_HP_PER_MS_2 4
`define HJD_INS_BASE_MS 16
`define HJD_INS_NONE 3'h7
`define HJD_REMOVAL_N0 5
`define HJD_REMOVAL_N1 3
`define HJD_HP_DEB_N 3
`define HJD_HOOK_N2 2
`define HJD_HOOK_N3 3

`endif

// File: core/hjd_pkg.sv
// Types shared by the headset jack detect logic
// Assumes the map header sits beside it on the include path
package hjd_pkg;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Comparator results and strap from the analog front end
    typedef struct packed {
        logic jack_present;
        logic mic_present;
        logic left_load;
        logic right_load;
        logic hook_pressed;
        logic external_resistor_type_bit;
    } hjd_sense_t;

    // Controls toward the analog front end
    typedef struct packed {
        logic headset_detect_enable;
        logic headphone_coupling_sel;
        logic double_sense_current_en;
        logic [1:0] hook_insert_threshold_sel;
        logic hook_threshold_valid;
        logic detector_pulse;
        logic headphone_sense_pulse;
    } hjd_ctrl_t;

    // Bus answer state
    typedef enum logic [2:0] {
        HJD_IDLE = 3'b001,
        HJD_ACCESS = 3'b010,
        HJD_DONE = 3'b100
    } hjd_bus_state_t;

endpackage : hjd_pkg

// File: core/hjd_debounce.sv
// Debounce counter for one detection result
// Assumes strobe is a one-cycle sample pulse on pclk, raw already synchronised
`timescale 1ns/10ps
module hjd_debounce
    import hjd_pkg::*;
#(
    parameter int CNT_W = 10
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic strobe,
    input wire logic raw,
    input wire logic [CNT_W-1:0] required,
    output logic accepted
);

    logic last;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    // Restart on a changed result, else count up with saturation
    always_comb
    begin
        if (raw != last)
            next_cnt = CNT_W'(1);
        else if (cnt == {CNT_W{1'b1}})
            next_cnt = cnt;
        else
            next_cnt = cnt + CNT_W'(1);
    end

    // Accept once enough identical results were seen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            accepted <= 1'b0;
            last <= 1'b0;
            cnt <= '0;
        end
        else if (clear)
        begin
            accepted <= 1'b0;
            last <= 1'b0;
            cnt <= '0;
        end
        else if (strobe)
        begin
            last <= raw;
            if (raw == accepted)
                cnt <= '0;
            else if (next_cnt >= required)
            begin
                accepted <= raw;
                cnt <= '0;
            end
            else
                cnt <= next_cnt;
        end
    end

endmodule : hjd_debounce

// File: core/hjd_top.sv
// Headset jack detect configuration, debounce and status with APB slave
// Assumes comparator inputs are asynchronous and pclk runs at 20 MHz
//
// Overview of operation
// - Detection runs only while the enable bit is one; reset leaves it off.
// - Coupling bit zero means AC coupled headphone load, one means DC coupled.
// - Current bit one selects double sense current, zero selects normal current.
// - Threshold code picks minimum hook impedance 150/100/50 ohm; only without external resistor.
// - Headphone debounce bit zero accepts each result, one needs three detections.
// - Insertion debounce code 0..5 gives 16..512 ms, 7 none, 6 reserved.
// - Removal needs five consecutive detections, or three when the bit is one.
// - Hook debounce code 0/1 none, 2 needs two, 3 needs three detections.
// - Jack state at bits 7-6: 0 out, 1 no mic, 3 with mic.
// - Headset type at bits 5-4: none, mono right, mono left, stereo.
// - Detector pulses at 0.5, 1, 7.5 or 15 Hz; each pulse is one detection.
// - Headphone sense period is 1, 2 or 4 ms; code 3 reserved.
//
// The APB interface to the registers is this design's own decision.
`include "hjd_map.svh"
`timescale 1ns/10ps
module hjd_top
    import hjd_pkg::*;
#(
    parameter int MS_CYCLES = `HJD_MS_CYCLES,
    parameter int ADDR_W = 12
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire hjd_sense_t sense_in,
    output hjd_ctrl_t ctrl_out,
    output logic irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam int MS_W = $clog2(MS_CYCLES + 1);
    localparam int DEB_W = 10;
    localparam int NCH = 5;
    localparam int CH_JACK = 0;
    localparam int CH_MIC = 1;
    localparam int CH_HOOK = 2;
    localparam int CH_LEFT = 3;
    localparam int CH_RIGHT = 4;

    if (MS_CYCLES < 2)
        $error("MS_CYCLES must be at least 2");
    if (ADDR_W < 10)
        $error("ADDR_W must reach the highest register index");

    // ------------------------------------------------------------------
    // Decoding functions
    // ------------------------------------------------------------------
    // Register hit for a given index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction : reg_hit

    // Detector pulse period in ms
    function automatic logic [11:0] rate_ms(input logic [1:0] code);
        case (code)
            2'h0: rate_ms = 12'(`HJD_DHZ_TO_MS / `HJD_RATE_DHZ_0);
            2'h1: rate_ms = 12'(`HJD_DHZ_TO_MS / `HJD_RATE_DHZ_1);
            2'h2: rate_ms = 12'(`HJD_DHZ_TO_MS / `HJD_RATE_DHZ_2);
            default: rate_ms = 12'(`HJD_DHZ_TO_MS / `HJD_RATE_DHZ_3);
        endcase
    endfunction : rate_ms

    // Headphone sense period in ms, reserved code falls back to 1 ms
    function automatic logic [11:0] hp_ms(input logic [1:0] code);
        case (code)
            2'h1: hp_ms = 12'(`HJD_HP_PER_MS_1);
            2'h2: hp_ms = 12'(`HJD_HP_PER_MS_2);
            default: hp_ms = 12'(`HJD_HP_PER_MS_0);
        endcase
    endfunction : hp_ms

    // Insertion debounce in ms ticks; reserved code 6 holds 512 ms
    function automatic logic [DEB_W-1:0] ins_ms(input logic [2:0] code);
        if (code == `HJD_INS_NONE)
            ins_ms = DEB_W'(1);
        else if (code > 3'h5)
            ins_ms = DEB_W'(`HJD_INS_BASE_MS << 5);
        else
            ins_ms = DEB_W'(`HJD_INS_BASE_MS << code);
    endfunction : ins_ms

    // Hook press repeat count
    function automatic logic [DEB_W-1:0] hook_n(input logic [1:0] code);
        case (code)
            2'h2: hook_n = DEB_W'(`HJD_HOOK_N2);
            2'h3: hook_n = DEB_W'(`HJD_HOOK_N3);
            default: hook_n = DEB_W'(1);
        endcase
    endfunction : hook_n

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [7:0] timing_cfg;
    logic [7:0] jack_detect_sense_config;
    logic [7:0] jack_detect_debounce_config;
    logic [`HJD_NUM_EVENTS-1:0] irq_status;
    logic [`HJD_NUM_EVENTS-1:0] irq_mask;
    hjd_bus_state_t bus_state;
    hjd_sense_t sense_meta;
    hjd_sense_t sense_sync;
    logic [MS_W-1:0] ms_cnt;
    logic ms_tick;
    logic [11:0] pulse_cnt;
    logic [11:0] hp_cnt;
    logic det_pulse;
    logic hp_pulse;
    logic [NCH-1:0] ch_raw;
    logic [NCH-1:0] ch_strobe;
    logic [DEB_W-1:0] ch_req [NCH];
    logic [NCH-1:0] ch_ok;
    logic [1:0] jack_type_flag;
    logic [1:0] headset_kind_flag;
    logic hook_seen;
    logic [`HJD_NUM_EVENTS-1:0] events;
    logic [7:0] next_status;
    logic [7:0] next_rdata;
    logic next_err;
    logic wr_done;
    logic mapped;
    logic det_on;

    assign det_on = jack_detect_sense_config[`HJD_SNS_ENABLE];

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bus_state <= HJD_IDLE;
        else
        begin
            case (bus_state)
                HJD_IDLE: bus_state <= (psel && !penable) ? HJD_ACCESS : HJD_IDLE;
                HJD_ACCESS: bus_state <= (psel && penable) ? HJD_DONE : HJD_ACCESS;
                HJD_DONE: bus_state <= (psel && !penable) ? HJD_ACCESS : HJD_IDLE;
                default: bus_state <= HJD_IDLE;
            endcase
        end
    end

    assign wr_done = pready && psel && penable && pwrite && !pslverr;
    assign mapped = reg_hit(paddr, `HJD_IDX_TIMING_CFG) || reg_hit(paddr, `HJD_IDX_SENSE_CFG)
        || reg_hit(paddr, `HJD_IDX_DEBOUNCE_CFG) || reg_hit(paddr, `HJD_IDX_STATUS)
        || reg_hit(paddr, `HJD_IDX_IRQ_STATUS) || reg_hit(paddr, `HJD_IDX_IRQ_MASK);

    // Read data mux, reserved and unmapped read zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_hit(paddr, `HJD_IDX_TIMING_CFG))
            next_rdata = timing_cfg;
        else if (reg_hit(paddr, `HJD_IDX_SENSE_CFG))
            next_rdata = jack_detect_sense_config;
        else if (reg_hit(paddr, `HJD_IDX_DEBOUNCE_CFG))
            next_rdata = jack_detect_debounce_config;
        else if (reg_hit(paddr, `HJD_IDX_STATUS))
            next_rdata = next_status;
        else if (reg_hit(paddr, `HJD_IDX_IRQ_STATUS))
            next_rdata = {4'h0, irq_status};
        else if (reg_hit(paddr, `HJD_IDX_IRQ_MASK))
            next_rdata = {4'h0, irq_mask};
        next_err = !mapped || (pwrite && reg_hit(paddr, `HJD_IDX_STATUS));
    end

    // Ready, read data and error come from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (bus_state == HJD_ACCESS && psel && penable)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
            pslverr <= next_err;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Configuration writes, only sense bit 0 and debounce bit 7 kept at reset value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timing_cfg <= `HJD_RST_TIMING_CFG;
            jack_detect_sense_config <= `HJD_RST_SENSE_CFG;
            jack_detect_debounce_config <= `HJD_RST_DEBOUNCE_CFG;
            irq_mask <= `HJD_RST_IRQ;
        end
        else if (wr_done && pstrb[0])
        begin
            if (reg_hit(paddr, `HJD_IDX_TIMING_CFG))
                timing_cfg <= pwdata[7:0] & `HJD_WMASK_TIMING_CFG;
            if (reg_hit(paddr, `HJD_IDX_SENSE_CFG))
                jack_detect_sense_config <= pwdata[7:0] & `HJD_WMASK_SENSE_CFG;
            if (reg_hit(paddr, `HJD_IDX_DEBOUNCE_CFG))
                jack_detect_debounce_config <= pwdata[7:0] & `HJD_WMASK_DEBOUNCE_CFG;
            if (reg_hit(paddr, `HJD_IDX_IRQ_MASK))
                irq_mask <= pwdata[`HJD_NUM_EVENTS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sense_meta <= '0;
            sense_sync <= '0;
        end
        else
        begin
            sense_meta <= sense_in;
            sense_sync <= sense_meta;
        end
    end

    // ------------------------------------------------------------------
    // Time base and detection pulses
    // ------------------------------------------------------------------
    // Millisecond tick, runs only while detection is on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
        end
        else if (!det_on)
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
        end
        else if (ms_cnt == MS_W'(MS_CYCLES - 1))
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b1;
        end
        else
        begin
            ms_cnt <= ms_cnt + MS_W'(1);
            ms_tick <= 1'b0;
        end
    end

    // Detector pulse at the chosen rate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_cnt <= 12'h000;
            det_pulse <= 1'b0;
        end
        else if (!det_on)
        begin
            pulse_cnt <= 12'h000;
            det_pulse <= 1'b0;
        end
        else if (ms_tick && pulse_cnt >= rate_ms(timing_cfg[`HJD_TIM_RATE_HI:`HJD_TIM_RATE_LO]) - 12'h001)
        begin
            pulse_cnt <= 12'h000;
            det_pulse <= 1'b1;
        end
        else
        begin
            pulse_cnt <= ms_tick ? pulse_cnt + 12'h001 : pulse_cnt;
            det_pulse <= 1'b0;
        end
    end

    // Headphone sense clock at the chosen period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hp_cnt <= 12'h000;
            hp_pulse <= 1'b0;
        end
        else if (!det_on)
        begin
            hp_cnt <= 12'h000;
            hp_pulse <= 1'b0;
        end
        else if (ms_tick && hp_cnt >= hp_ms(timing_cfg[`HJD_TIM_HP_PER_HI:`HJD_TIM_HP_PER_LO]) - 12'h001)
        begin
            hp_cnt <= 12'h000;
            hp_pulse <= 1'b1;
        end
        else
        begin
            hp_cnt <= ms_tick ? hp_cnt + 12'h001 : hp_cnt;
            hp_pulse <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Debounce channels
    // ------------------------------------------------------------------
    // Insertion counts ms ticks, removal counts detector pulses
    always_comb
    begin
        ch_raw = {sense_sync.right_load, sense_sync.left_load, sense_sync.hook_pressed,
                  sense_sync.mic_present, sense_sync.jack_present};
        ch_strobe[CH_JACK] = ch_ok[CH_JACK] ? det_pulse : ms_tick;
        ch_req[CH_JACK] = ch_ok[CH_JACK]
            ? (jack_detect_debounce_config[`HJD_DEB_REMOVAL] ? DEB_W'(`HJD_REMOVAL_N1)
                                                             : DEB_W'(`HJD_REMOVAL_N0))
            : ins_ms(jack_detect_debounce_config[`HJD_DEB_INS_HI:`HJD_DEB_INS_LO]);
        ch_strobe[CH_MIC] = det_pulse;
        ch_req[CH_MIC] = DEB_W'(1);
        ch_strobe[CH_HOOK] = det_pulse;
        ch_req[CH_HOOK] = hook_n(jack_detect_debounce_config[`HJD_DEB_HOOK_HI:`HJD_DEB_HOOK_LO]);
        ch_strobe[CH_LEFT] = hp_pulse;
        ch_strobe[CH_RIGHT] = hp_pulse;
        ch_req[CH_LEFT] = jack_detect_debounce_config[`HJD_DEB_HP] ? DEB_W'(`HJD_HP_DEB_N)
                                                                   : DEB_W'(1);
        ch_req[CH_RIGHT] = ch_req[CH_LEFT];
    end

    for (genvar i = 0; i < NCH; i++)
    begin : g_deb
        hjd_debounce #(
            .CNT_W(DEB_W)
        ) u_deb (
            .pclk(pclk),
            .presetn(presetn),
            .clear(!det_on),
            .strobe(ch_strobe[i]),
            .raw(ch_raw[i]),
            .required(ch_req[i]),
            .accepted(ch_ok[i])
        );
    end

    // ------------------------------------------------------------------
    // Status and interrupts
    // ------------------------------------------------------------------
    // Jack and headset type from accepted results
    always_comb
    begin
        if (!ch_ok[CH_JACK])
            next_status = 8'h00;
        else
            next_status = {ch_ok[CH_MIC] ? 2'h3 : 2'h1,
                           ch_ok[CH_LEFT], ch_ok[CH_RIGHT], 4'h0};
    end

    // Registered status copy for change detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jack_type_flag <= 2'h0;
            headset_kind_flag <= 2'h0;
            hook_seen <= 1'b0;
        end
        else
        begin
            jack_type_flag <= next_status[7:6];
            headset_kind_flag <= next_status[5:4];
            hook_seen <= ch_ok[CH_HOOK];
        end
    end

    assign events[`HJD_EV_JACK] = next_status[7:6] != jack_type_flag;
    assign events[`HJD_EV_HEADSET] = next_status[5:4] != headset_kind_flag;
    assign events[`HJD_EV_HOOK_PRESS] = ch_ok[CH_HOOK] && !hook_seen;
    assign events[`HJD_EV_HOOK_RELEASE] = !ch_ok[CH_HOOK] && hook_seen;

    // Sticky status, write one clears, a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= `HJD_RST_IRQ;
        else if (wr_done && pstrb[0] && reg_hit(paddr, `HJD_IDX_IRQ_STATUS))
            irq_status <= (irq_status & ~pwdata[`HJD_NUM_EVENTS-1:0]) | events;
        else
            irq_status <= irq_status | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    // ------------------------------------------------------------------
    // Analog front end controls
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_out <= '0;
        else
        begin
            ctrl_out.headset_detect_enable <= det_on;
            ctrl_out.headphone_coupling_sel <= jack_detect_sense_config[`HJD_SNS_COUPLING];
            ctrl_out.double_sense_current_en <= jack_detect_sense_config[`HJD_SNS_DOUBLE_CUR];
            ctrl_out.hook_insert_threshold_sel <=
                jack_detect_sense_config[`HJD_SNS_THRESH_HI:`HJD_SNS_THRESH_LO];
            ctrl_out.hook_threshold_valid <= !sense_sync.external_resistor_type_bit;
            ctrl_out.detector_pulse <= det_pulse;
            ctrl_out.headphone_sense_pulse <= hp_pulse;
        end
    end

endmodule : hjd_top

// File: dv/hjd_jack_model.sv
// Behavioural headset or headphone plugged into the jack comparators
// Assumes the bench picks the plug kind and the microphone level
`timescale 1ns/10ps
module hjd_jack_model
    import hjd_pkg::*;
(
    input wire logic [1:0] plug_kind,
    input wire logic mic_fitted,
    input wire logic hook,
    input wire logic ext_res,
    output hjd_sense_t sense
);
    // Comparator levels; plug kind 1 right only, 2 left only, 3 both
    assign sense = '{plug_kind != 2'h0, mic_fitted && plug_kind != 2'h0,
        plug_kind[1], plug_kind[0], hook && plug_kind != 2'h0, ext_res};
endmodule : hjd_jack_model

// File: dv/hjd_top_sva.sv
// Checker on the headset jack detect top ports
// Assumes it is bound into hjd_top
`timescale 1ns/10ps
module hjd_top_sva
    import hjd_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire hjd_ctrl_t ctrl_out,
    input wire logic irq
);
    // ----------
    // Properties
    // ----------
    wire logic [11:0] a = 12'(paddr);
    wire logic hit = a == 12'h064 || a == 12'h068 || a == 12'h06C || a == 12'h070
        || a == 12'h080 || a == 12'h084;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Completed access
    sequence s_done;
        psel && penable && pready;
    endsequence
    chk_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    chk_unmapped_err: assert property (s_done ##0 !hit |-> pslverr)
        else $error("no error on unmapped");
    chk_status_ro: assert property (s_done ##0 (pwrite && a == 12'h070) |-> pslverr)
        else $error("status write taken");
    chk_jack_code: assert property (s_done ##0 (!pwrite && a == 12'h070)
        |-> prdata[7:6] != 2'h2 && prdata[3:0] == 4'h0)
        else $error("bad status code");
    chk_sense_ctrl: assert property (s_done ##0 (pwrite && a == 12'h068 && pstrb[0])
        |-> ##2 ctrl_out[7:3] == $past({pwdata[1], pwdata[3:2], pwdata[5:4]}, 2))
        else $error("sense controls wrong");
    chk_idle_quiet: assert property (!ctrl_out.headset_detect_enable [*3]
        |-> !ctrl_out.detector_pulse && !ctrl_out.headphone_sense_pulse)
        else $error("pulse while disabled");
    chk_irq_clear: assert property ($fell(irq) |-> $past(pwrite && pready, 2))
        else $error("irq fell without write");
endmodule : hjd_top_sva

bind hjd_top hjd_top_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_out(ctrl_out), .irq(irq));

// File: dv/tb_headset_jack_detect_logic.sv
// Testbench for the headset jack detect logic over APB
// Assumes the jack model on the sense inputs and a 20 MHz pclk
`timescale 1ns/10ps
module tb_headset_jack_detect_logic;
    import hjd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext = 1'b0, mic = 1'b0, hook = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h1;
    logic [31:0] prdata;
    logic pready, pslverr, irq, err;
    logic [1:0] plug = 2'h0;
    logic [7:0] rd;
    hjd_sense_t sense;
    hjd_ctrl_t ctrl;
    int fail_count = 0, n_compared = 0;
    always #25 pclk = ~pclk;
    hjd_jack_model jack (.plug_kind(plug), .mic_fitted(mic), .hook(hook), .ext_res(ext),
        .sense(sense));
    hjd_top #(.MS_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_in(sense),
        .ctrl_out(ctrl), .irq(irq));
    // ----------
    // Tasks
    // ----------
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; read data and error land in rd and err
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        check("pready", {7'h00, pready}, 8'h01);
        if (pready !== 1'b1)
            end_of_test;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Poll the status register until it matches, bounded
    task wait_status(input logic [7:0] exp);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, 12'h070, 8'h00);
            n++;
        end
        while (rd !== exp && n < 800);
        check("status", rd, exp);
        if (rd !== exp)
            end_of_test;
    endtask : wait_status
    // ----------
    // Sequence
    // ----------
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h068, 8'h00);
        check("sense", rd, 8'h00);
        apb(1'b1, 12'h06C, 8'h7F);
        apb(1'b0, 12'h06C, 8'h00);
        check("debounce", rd, 8'h7F);
        apb(1'b1, 12'h070, 8'h00);
        check("status write err", {7'h00, err}, 8'h01);
        apb(1'b0, 12'h0FC, 8'h00);
        check("unmapped err", {7'h00, err}, 8'h01);
        apb(1'b1, 12'h068, 8'h2C);
        repeat (2) @(negedge pclk);
        check("controls", {2'h0, ctrl[7:2]}, 8'h1D);
        @(posedge pclk);
        ext <= 1'b1;
        repeat (4) @(negedge pclk);
        check("threshold valid", {7'h00, ctrl[2]}, 8'h00);
        $display("test registers done");
        apb(1'b1, 12'h06C, 8'h00);
        apb(1'b1, 12'h064, 8'hC0);
        apb(1'b1, 12'h084, 8'h01);
        plug <= 2'h3;
        mic <= 1'b1;
        apb(1'b1, 12'h068, 8'h02);
        wait_status(8'hF0);
        @(negedge pclk);
        check("irq set", {7'h00, irq}, 8'h01);
        apb(1'b1, 12'h080, 8'h0F);
        repeat (2) @(negedge pclk);
        check("irq cleared", {7'h00, irq}, 8'h00);
        @(posedge pclk);
        hook <= 1'b1;
        repeat (600) @(posedge pclk);
        apb(1'b0, 12'h080, 8'h00);
        check("hook press", rd, 8'h04);
        $display("test insertion done");
        plug <= 2'h1;
        mic <= 1'b0;
        wait_status(8'h50);
        plug <= 2'h2;
        wait_status(8'h60);
        apb(1'b1, 12'h068, 8'h00);
        wait_status(8'h00);
        apb(1'b1, 12'h06C, 8'h7C);
        apb(1'b1, 12'h068, 8'h02);
        wait_status(8'h60);
        plug <= 2'h0;
        wait_status(8'h00);
        $display("test types and removal done");
        end_of_test;
    end
endmodule : tb_headset_jack_detect_logic
